/* rert_timer.sv */
// rising-edge reflex timer with register port and output routing
// assumes island, virtual and master bits arrive asynchronously;
// nested input comes from logic on mclk_in
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
module rert_timer
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic module_bit_in,
   input wire logic virtual_bit_in,
   input wire logic master_bit_in,
   input wire logic enable_bit_in,
   input wire logic timer_rst_n_in,
   input wire logic nested_bit_in,
   input wire logic master_out_bit_in,
   input wire logic [2:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output logic channel_out,
   output logic nested_out,
   output logic running_out
);
   import rert_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // register map (word index)
   localparam logic [2:0] reg_ctrl = 3'h0;
   localparam logic [2:0] reg_final = 3'h1;
   localparam logic [2:0] reg_status = 3'h2;
   localparam logic [2:0] reg_acc = 3'h3;
   // ctrl fields
   localparam int unsigned f_unit = 0;
   localparam int unsigned f_trg = 3;
   localparam int unsigned f_en = 6;
   localparam int unsigned f_inv = 8;
   localparam int unsigned f_const = 9;
   localparam int unsigned f_nest = 10;
   localparam logic [15:0] ctrl_rst = 16'h0000;
   localparam logic [14:0] final_rst = 15'h0000;

   // one strobe against one decoded word index
   function automatic logic reg_hit(input logic strobe,
                                    input logic [2:0] addr,
                                    input logic [2:0] word);
      reg_hit = strobe && addr == word;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [5:0] sync_q;

   rert_sync u_sync
   (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .d_in({master_out_bit_in, timer_rst_n_in, enable_bit_in,
             master_bit_in, virtual_bit_in, module_bit_in}),
      .q_out(sync_q)
   );

   // taps: module, virtual, master, enable, timer reset, channel data
   logic rst_ok;
   logic en_pin;
   logic master_data;
   assign rst_ok = sync_q[4];
   assign en_pin = sync_q[3];
   assign master_data = sync_q[5];

   ////////////////////////////////////////////////////////////////////////
   // register port
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [14:0] final_unit_count_reg;
   logic [14:0] final_unit_count_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   rert_unit_t unit_sel;
   rert_src_t trg_sel;
   rert_en_mode_t en_mode;
   logic inv_sel;
   logic const_val;
   logic nest_sel;

   assign unit_sel = rert_unit_t'(ctrl_reg[f_unit +: 3]);
   assign trg_sel = rert_src_t'(ctrl_reg[f_trg +: 3]);
   assign en_mode = rert_en_mode_t'(ctrl_reg[f_en +: 2]);
   assign inv_sel = ctrl_reg[f_inv];
   assign const_val = ctrl_reg[f_const];
   assign nest_sel = ctrl_reg[f_nest];

   ////////////////////////////////////////////////////////////////////////
   // timer state declarations
   rert_state_t state_reg;
   rert_state_t state_next;
   logic [14:0] acc_reg;
   logic [14:0] acc_next;
   logic [17:0] base_reg;
   logic [17:0] base_next;
   logic [13:0] pre_reg;
   logic [13:0] pre_next;
   logic trg_prev_reg;
   logic trg_prev_next;
   logic en_prev_reg;
   logic en_prev_next;
   logic rst_prev_reg;
   logic rst_prev_next;
   logic out_reg;
   logic out_next;
   logic chan_reg;
   logic chan_next;
   logic nout_reg;
   logic nout_next;
   logic run_reg;
   logic run_next;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      final_unit_count_next = final_unit_count_reg;
      rdata_next = 16'h0000;
      // unmapped words read as zero and drop writes
      if (reg_hit(wr_in, addr_in, reg_ctrl))
         ctrl_next = wdata_in;
      if (reg_hit(wr_in, addr_in, reg_final))
         final_unit_count_next = wdata_in[14:0];
      if (rd_in)
      begin
         case (addr_in)
            reg_ctrl: rdata_next = ctrl_reg;
            reg_final: rdata_next = {1'b0, final_unit_count_reg};
            reg_status: rdata_next = {13'h0000, state_reg};
            reg_acc: rdata_next = {1'b0, acc_reg};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ctrl_reg <= ctrl_rst;
         final_unit_count_reg <= final_rst;
         rdata_reg <= 16'h0000;
      end
      else if (ce_in)
      begin
         ctrl_reg <= ctrl_next;
         final_unit_count_reg <= final_unit_count_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger and enable selection
   logic trg;
   logic en;

   always_comb
   begin
      case (trg_sel)
         rert_src_const: trg = const_val;
         rert_src_module: trg = sync_q[0];
         rert_src_virtual: trg = sync_q[1];
         rert_src_master: trg = sync_q[2];
         rert_src_nested: trg = nested_bit_in;
         default: trg = 1'b0;
      endcase
      case (en_mode)
         rert_en_bit: en = en_pin;
         rert_en_always: en = 1'b1;
         rert_en_never: en = 1'b0;
         default: en = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // timer core
   logic start;
   logic tick;
   logic base_wrap;
   logic [13:0] unit_top;

   // divider wraps once per ms; prescaler once per unit. >= keeps a unit
   // change mid-run from stranding the prescaler above its new top
   assign base_wrap = base_reg == base_max;
   assign unit_top = rert_unit_max(unit_sel);

   // trigger edges seen while disabled are not acted on; on enable or on
   // timer reset release a high trigger counts as an edge
   assign start = en && rst_ok && trg &&
                  (!trg_prev_reg || !en_prev_reg || !rst_prev_reg);
   assign tick = base_wrap && pre_reg >= unit_top;

   always_comb
   begin
      state_next = state_reg;
      acc_next = acc_reg;
      base_next = base_reg + 18'h00001;
      pre_next = pre_reg;
      if (base_wrap)
      begin
         base_next = base_zero;
         if (pre_reg >= unit_top)
            pre_next = pre_zero;
         else
            pre_next = pre_reg + 14'h0001;
      end
      trg_prev_next = trg;
      en_prev_next = en;
      rst_prev_next = rst_ok;
      if (!rst_ok)
      begin
         state_next = rert_st_idle;
         acc_next = count_zero;
      end
      else if (start)
      begin
         acc_next = count_zero;
         base_next = base_zero;
         pre_next = pre_zero;
         state_next = (final_unit_count_reg == count_zero) ?
                      rert_st_done : rert_st_count;
      end
      else
      begin
         case (state_reg)
            rert_st_idle: state_next = rert_st_idle;
            rert_st_count:
            begin
               // run completes even while disabled
               if (tick)
               begin
                  acc_next = acc_reg + count_one;
                  if (acc_reg + count_one >= final_unit_count_reg)
                     state_next = rert_st_done;
               end
            end
            rert_st_done: state_next = rert_st_done;
            default: state_next = rert_st_idle;
         endcase
      end
      // output frozen while disabled, except timer reset forces inactive
      run_next = state_next == rert_st_count;
      if (!rst_ok)
         out_next = inv_sel;
      else if (en)
         out_next = run_next ^ inv_sel;
      else
         out_next = out_reg;
      // channel ignores master data once mapped to the block
      if (nest_sel)
      begin
         chan_next = master_data;
         nout_next = out_next;
      end
      else
      begin
         chan_next = out_next;
         nout_next = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_reg <= rert_st_idle;
         acc_reg <= count_zero;
         base_reg <= base_zero;
         pre_reg <= pre_zero;
         trg_prev_reg <= 1'b0;
         en_prev_reg <= 1'b0;
         rst_prev_reg <= 1'b0;
         out_reg <= 1'b0;
         chan_reg <= 1'b0;
         nout_reg <= 1'b0;
         run_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         base_reg <= base_next;
         pre_reg <= pre_next;
         trg_prev_reg <= trg_prev_next;
         en_prev_reg <= en_prev_next;
         rst_prev_reg <= rst_prev_next;
         out_reg <= out_next;
         chan_reg <= chan_next;
         nout_reg <= nout_next;
         run_reg <= run_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign channel_out = chan_reg;
   assign nested_out = nout_reg;
   assign running_out = run_reg;
endmodule // rert_timer

/* rert_pkg.sv */
// constants and types for the rising-edge reflex timer
// assumes a single 250 mhz clock domain
//
// Summary of operation
// - a timing run starts on a low-to-high trigger transition, or on enable or timer reset release with trigger high
// - time unit selectable among 1, 10, 100, 1000 or 10000 ms
// - terminal count is any integer from 0 to 32767
// - count upward from zero, stop and hold at the terminal count
// - normal output high while counting, low at zero or terminal count
// - inverted output low while counting, high otherwise
// - after terminal count output stays off until a new trigger edge
// - enabled by high enable bit or always-on; disabled by low or always-off
// - while disabled a started run completes but the output stays frozen
// - on re-enable the block acts at once on latest inputs
// - trigger high at enable counts as an edge; low waits for edge
// - timer reset input is active low; timer idles while it is low
// - reset low mid-count stops count and drives output inactive
// - reset release with trigger high restarts count from zero
// - trigger selectable: constant, module input, virtual, master bit, nest
// - as first nested block the output feeds the second block
// - driven output channel ignores master data; master bit stays an input
package rert_pkg;
   localparam int unsigned clk_mhz = 250;
   localparam int unsigned base_us = 1000;
   localparam int unsigned base_cycles = base_us * clk_mhz;
   localparam logic [17:0] base_max = 18'(base_cycles - 1);
   localparam int unsigned count_w = 15;
   localparam logic [14:0] count_zero = 15'h0000;
   localparam logic [14:0] count_one = 15'h0001;
   localparam logic [13:0] pre_zero = 14'h0000;
   localparam logic [17:0] base_zero = 18'h00000;

   // time unit selection codes
   typedef enum logic [2:0]
   {
      rert_unit_1ms = 3'h0,
      rert_unit_10ms = 3'h1,
      rert_unit_100ms = 3'h2,
      rert_unit_1000ms = 3'h3,
      rert_unit_10000ms = 3'h4
   } rert_unit_t;

   // trigger source selection
   typedef enum logic [2:0]
   {
      rert_src_const = 3'h0,
      rert_src_module = 3'h1,
      rert_src_virtual = 3'h2,
      rert_src_master = 3'h3,
      rert_src_nested = 3'h4
   } rert_src_t;

   typedef enum logic [1:0]
   {
      rert_en_bit = 2'h0,
      rert_en_always = 2'h1,
      rert_en_never = 2'h2
   } rert_en_mode_t;

   typedef enum logic [2:0]
   {
      rert_st_idle = 3'b001,
      rert_st_count = 3'b010,
      rert_st_done = 3'b100
   } rert_state_t;

   // number of 1 ms ticks per unit, minus one
   function automatic logic [13:0] rert_unit_max(input rert_unit_t u);
      case (u)
         rert_unit_1ms: rert_unit_max = 14'h0000;
         rert_unit_10ms: rert_unit_max = 14'h0009;
         rert_unit_100ms: rert_unit_max = 14'h0063;
         rert_unit_1000ms: rert_unit_max = 14'h03e7;
         rert_unit_10000ms: rert_unit_max = 14'h270f;
         default: rert_unit_max = 14'h0000;
      endcase
   endfunction
endpackage

/* rert_sync.sv */
// two-flop synchroniser for a group of pin-level inputs
// assumes inputs are asynchronous to mclk_in
`timescale 1ns/100ps
module rert_sync
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic [5:0] d_in,
   output logic [5:0] q_out
);
   logic [5:0] s1_reg;
   logic [5:0] s2_reg;
   logic [5:0] s1_next;
   logic [5:0] s2_next;

   always_comb
   begin
      s1_next = ce_in ? d_in : s1_reg;
      s2_next = ce_in ? s1_reg : s2_reg;
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s1_reg <= 6'h00;
         s2_reg <= 6'h00;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   assign q_out = s2_reg;
endmodule // rert_sync

/* rert_island_model.sv */
// island i/o and master bit model for the timer bench
// assumes the bench sets wanted pin levels at a rising edge
`timescale 1ns/100ps
module rert_island_model
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [5:0] want_in,
   output logic [5:0] pins_out
);
   // pins move one edge late, like a scanned i/o image
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         pins_out <= 6'h00;
      else
         pins_out <= want_in;
   end
endmodule // rert_island_model

/* rert_timer_properties.sv */
// port checker for rert_timer
// assumes control words reach the block only via the register port
`timescale 1ns/100ps
module rert_timer_chk
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic timer_rst_n_in,
   input wire logic [2:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic channel_out,
   input wire logic nested_out,
   input wire logic running_out
);
   logic [10:0] ctl_reg;
   logic [14:0] fin_reg;
   logic [2:0] age_reg;
   logic [2:0] hi_reg;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   //////////////////////////////////////////////////////////
   // shadow copies; ages mask the settling after a change
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ctl_reg <= '0;
         fin_reg <= '0;
         age_reg <= '0;
         hi_reg <= '0;
      end
      else
      begin
         if (ce_in && wr_in && addr_in == 3'h0)
            ctl_reg <= wdata_in[10:0];
         if (ce_in && wr_in && addr_in == 3'h1)
            fin_reg <= wdata_in[14:0];
         if (ce_in && wr_in && addr_in == 3'h0)
            age_reg <= 3'h0;
         else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
         if (!timer_rst_n_in)
            hi_reg <= 3'h0;
         else if (hi_reg != 3'h7)
            hi_reg <= hi_reg + 3'h1;
      end
   end
   //////////////////////////////////////////////////////////
   a_rdata_idle: assert property (ce_in && !rd_in |=> rdata_out == 16'h0)
      else $error("read data not zero outside a read");
   a_final_readback: assert property
      (ce_in && rd_in && addr_in == 3'h1 |=> rdata_out == {1'b0, fin_reg})
      else $error("final count readback wrong");
   a_status_onehot: assert property
      (ce_in && rd_in && addr_in == 3'h2 |=>
       rdata_out inside {16'h1, 16'h2, 16'h4})
      else $error("status not one-hot");
   a_treset_idle: assert property
      ((ce_in && !timer_rst_n_in)[*4] |-> !running_out)
      else $error("running while timer reset low");
   a_chan_follow: assert property
      (age_reg == 3'h7 && ctl_reg[7:6] == 2'h1 && !ctl_reg[10] |->
       channel_out == (running_out ^ ctl_reg[8]))
      else $error("channel not running xor invert");
   a_nested_idle: assert property
      (age_reg == 3'h7 && !ctl_reg[10] |-> !nested_out)
      else $error("nested output active without nesting");
   a_nested_follow: assert property
      (age_reg == 3'h7 && ctl_reg[7:6] == 2'h1 && ctl_reg[10] |->
       nested_out == (running_out ^ ctl_reg[8]))
      else $error("nested output wrong");
   a_disabled_freeze: assert property
      (age_reg == 3'h7 && hi_reg == 3'h7 && ctl_reg[7:6] == 2'h2 &&
       !ctl_reg[10] |-> $stable(channel_out) && $stable(nested_out))
      else $error("output moved while disabled");
   c_run_start: cover property ($rose(running_out));
   c_inverted_run: cover property (ctl_reg[8] && running_out);
   c_nested_run: cover property (nested_out && running_out);
endmodule // rert_timer_chk

bind rert_timer rert_timer_chk chk (.mclk_in, .nrst_in, .ce_in,
   .timer_rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .channel_out, .nested_out, .running_out);

/* rert_timer_tb.sv */
// self-checking bench for rert_timer
// assumes no 1 ms tick lands in this short run
`timescale 1ns/100ps
module rert_timer_tb;
   import rert_pkg::*;
   logic mclk_in, nrst_in, ce_in, wr_in, rd_in, nest_in, chan, nout, run;
   logic [2:0] addr_in;
   logic [15:0] wdata_in, rdata_out;
   logic [5:0] want, pins;
   int n_mismatch, n_checks;
   rert_island_model island (.mclk_in, .nrst_in, .want_in(want),
      .pins_out(pins));
   rert_timer dut (.mclk_in, .nrst_in, .ce_in,
      .module_bit_in(pins[0]), .virtual_bit_in(pins[1]),
      .master_bit_in(pins[2]), .enable_bit_in(pins[3]),
      .timer_rst_n_in(pins[4]), .nested_bit_in(nest_in),
      .master_out_bit_in(pins[5]), .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .channel_out(chan), .nested_out(nout), .running_out(run));
   //////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge mclk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
   endtask
   // pin inputs pass model, sync and state: six edges covers it
   task automatic setp(input logic [5:0] v, input logic n);
      @(posedge mclk_in);
      want <= v;
      nest_in <= n;
      cyc(6);
   endtask
   task automatic outs(input logic [2:0] e);
      #1 chk({13'h0, nout, chan, run}, {13'h0, e});
   endtask
   task automatic stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////
   initial
   begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end
   initial
   begin
      cyc(6000);
      n_mismatch++;
      stop_test;
   end
   initial
   begin
      nrst_in = 1'b0;
      ce_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 3'h0;
      wdata_in = 16'h0;
      want = 6'h10;
      nest_in = 1'b0;
      cyc(10);
      nrst_in <= 1'b1;
      rd(3'h1, 16'h0000);
      wr(3'h1, 16'hffff);
      rd(3'h1, 16'h7fff);
      rd(3'h5, 16'h0000);
      for (int u = 0; u < 5; u++)
      begin
         wr(3'h0, 16'(16'h0040 + u));
         wr(3'h0, 16'(16'h0240 + u));
         cyc(3);
         outs(3'b011);
         rd(3'h3, 16'h0000);
         rd(3'h0, 16'(16'h0240 + u));
      end
      wr(3'h0, 16'h0340);
      cyc(3);
      outs(3'b001);
      setp(6'h00, 1'b0);
      outs(3'b010);
      setp(6'h10, 1'b0);
      outs(3'b001);
      rd(3'h3, 16'h0000);
      wr(3'h1, 16'h0000);
      wr(3'h0, 16'h0040);
      wr(3'h0, 16'h0240);
      cyc(3);
      outs(3'b000);
      rd(3'h2, 16'h0004);
      // enable from the pin: edges while disabled must be dropped
      wr(3'h1, 16'h0005);
      wr(3'h0, 16'h0000);
      wr(3'h0, 16'h0200);
      cyc(3);
      rd(3'h2, 16'h0004);
      setp(6'h18, 1'b0);
      rd(3'h2, 16'h0002);
      outs(3'b011);
      setp(6'h10, 1'b0);
      wr(3'h0, 16'h0300);
      cyc(3);
      outs(3'b011);
      wr(3'h0, 16'h0380);
      cyc(8);
      outs(3'b011);
      wr(3'h0, 16'h0340);
      cyc(3);
      outs(3'b001);
      for (int s = 1; s < 5; s++)
      begin
         wr(3'h0, 16'(16'h0040 + (s << 3)));
         setp(6'h00, 1'b0);
         setp(6'h10, 1'b0);
         rd(3'h2, 16'h0001);
         setp(6'h10 | (6'(1 << (s - 1)) & 6'h07), s == 4);
         rd(3'h2, 16'h0002);
      end
      wr(3'h0, 16'h0440);
      wr(3'h0, 16'h0640);
      cyc(3);
      outs(3'b101);
      setp(6'h30, 1'b0);
      outs(3'b111);
      wr(3'h1, 16'h0000);
      wr(3'h0, 16'h0040);
      wr(3'h0, 16'h0240);
      cyc(3);
      outs(3'b000);
      // clock enable low: writes dropped, outputs held
      @(posedge mclk_in);
      ce_in <= 1'b0;
      wr(3'h1, 16'h0007);
      wr(3'h0, 16'h0340);
      outs(3'b000);
      @(posedge mclk_in);
      ce_in <= 1'b1;
      rd(3'h1, 16'h0000);
      rd(3'h0, 16'h0240);
      stop_test;
   end
endmodule // rert_timer_tb
